// ===== rtl/sbvc_regs.sv
/*
 * register bank for prescaler and lo buffer bias, loop bandwidth scaling and
 * vco calibration control, reached over the four-wire serial config bus.
 * assumes the bus pins are asynchronous to mclk_i and much slower than it,
 * and that an external calibration engine pulses cal_done_i when finished.
 */
`timescale 1ns/1ps
`default_nettype none
module sbvc_regs
    import sbvc_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        pclk_i,
    input  wire logic        pdi_i,
    input  wire logic        psel_n_i,
    output logic             pdo_o,
    input  wire logic        freq_select_i,
    input  wire logic [3:0]  lock_select_i,
    input  wire logic        cal_done_i,
    output logic [1:0]       prescaler_swing_o,
    output logic [2:0]       tx_lo_swing_o,
    output logic [1:0]       prescaler_current_o,
    output logic [2:0]       tx_lo_current_o,
    output logic [7:0]       loop_bandwidth_factor_o,
    output logic             cal_start_o,
    output logic [8:0]       cal_divider_o,
    output logic [17:0]      cal_time_est_o,
    output logic [3:0]       calibration_dac_start_o,
    output logic             cal_store_a_o,
    output logic             cal_store_b_o,
    output logic             lock_o
);
    sbvc_state_type s_q;
    sbvc_state_type s_d;
    logic           rise;
    logic           fall;
    logic [7:0]     wdata;

    always_comb begin
        s_d = s_q;
        // only stages 1 and 2 feed the filter; stage 0 may be metastable
        s_d.sync.pclk   = {s_q.sync.pclk[1:0], pclk_i};
        s_d.sync.pdi    = {s_q.sync.pdi[1:0], pdi_i};
        s_d.sync.psel_n = {s_q.sync.psel_n[1:0], psel_n_i};
        if (s_q.sync.pclk[1] == s_q.sync.pclk[2]) begin
            s_d.pclk = s_q.sync.pclk[2];
        end
        if (s_q.sync.pdi[1] == s_q.sync.pdi[2]) begin
            s_d.pdi = s_q.sync.pdi[2];
        end
        if (s_q.sync.psel_n[1] == s_q.sync.psel_n[2]) begin
            s_d.psel_n = s_q.sync.psel_n[2];
        end
        rise  = s_d.pclk & ~s_q.pclk;
        fall  = ~s_d.pclk & s_q.pclk;
        wdata = {s_q.shift[6:0], s_q.pdi};
        s_d.cal_pulse = 1'b0;
        if (s_q.regs.start) begin
            s_d.regs.start = 1'b0;
        end
        if (s_q.psel_n) begin
            s_d.bitcnt = 5'h00;
            s_d.pdo    = 1'b0;
        end else if (rise && s_q.bitcnt <= SBVC_BIT_LAST) begin
            s_d.bitcnt = s_q.bitcnt + 5'h01;
            s_d.shift  = wdata;
            if (s_q.bitcnt < SBVC_BIT_RW) begin
                s_d.addr = {s_q.addr[5:0], s_q.pdi};
            end
            if (s_q.bitcnt == SBVC_BIT_RW) begin
                s_d.wr = s_q.pdi;
                s_d.rd = sbvc_read(s_q.regs, s_q.addr);
            end
            if (s_q.bitcnt == SBVC_BIT_LAST && s_q.wr) begin
                unique case (s_q.addr)
                    SBVC_OFS_SWING: begin
                        s_d.regs.pre_swing = wdata[SBVC_POS_PRE +: 2];
                        s_d.regs.tx_swing  = wdata[2:0];
                    end
                    SBVC_OFS_CURRENT: begin
                        s_d.regs.pre_current = wdata[SBVC_POS_PRE +: 2];
                        s_d.regs.tx_current  = wdata[2:0];
                    end
                    SBVC_OFS_BW: begin
                        s_d.regs.bw = wdata;
                    end
                    SBVC_OFS_CAL: begin
                        s_d.regs.dual     = wdata[SBVC_POS_DUAL];
                        s_d.regs.wait_sel = wdata[SBVC_POS_WAIT +: 2];
                        s_d.regs.select   = wdata[SBVC_POS_SELECT];
                        s_d.regs.iterate  = wdata[2:0];
                        // launch on every write of 1 to the start bit, since the stored bit self-clears the cycle after
                        if (wdata[SBVC_POS_START] && !s_q.regs.start) begin
                            s_d.regs.start = 1'b1;
                            s_d.cal_pulse  = 1'b1;
                        end
                    end
                    default: begin
                        s_d.regs = s_d.regs;
                    end
                endcase
            end
        end else if (fall && !s_q.wr && s_q.bitcnt > SBVC_BIT_RW) begin
            s_d.pdo = s_q.rd[7];
            s_d.rd  = {s_q.rd[6:0], 1'b0};
        end
        // completion set beats the clear by a new launch
        if (cal_done_i) begin
            s_d.cal_done = 1'b1;
        end else if (s_d.cal_pulse) begin
            s_d.cal_done = 1'b0;
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.sync.pclk   <= 3'h0;
            s_q.sync.psel_n <= 3'h7;
            s_q.psel_n      <= 1'b1;
            s_q.regs.pre_swing   <= SBVC_RST_PRE_SWING;
            s_q.regs.tx_swing    <= SBVC_RST_TX_SWING;
            s_q.regs.pre_current <= SBVC_RST_PRE_CURRENT;
            s_q.regs.tx_current  <= SBVC_RST_TX_CURRENT;
            s_q.regs.bw          <= SBVC_RST_BW;
            s_q.regs.start       <= SBVC_RST_START;
            s_q.regs.dual        <= SBVC_RST_DUAL;
            s_q.regs.wait_sel    <= SBVC_RST_WAIT;
            s_q.regs.select      <= SBVC_RST_SELECT;
            s_q.regs.iterate     <= SBVC_RST_ITERATE;
        end else begin
            s_q <= s_d;
        end
    end

    assign pdo_o                   = s_q.pdo;
    assign prescaler_swing_o       = s_q.regs.pre_swing;
    assign tx_lo_swing_o           = s_q.regs.tx_swing;
    assign prescaler_current_o     = s_q.regs.pre_current;
    assign tx_lo_current_o         = s_q.regs.tx_current;
    assign loop_bandwidth_factor_o = s_q.regs.bw;
    assign cal_start_o             = s_q.cal_pulse;
    assign cal_divider_o           = sbvc_divider(s_q.regs.select, s_q.regs.wait_sel);
    assign calibration_dac_start_o = {1'b0, s_q.regs.iterate} + 4'h1;
    assign cal_store_a_o           = s_q.regs.dual | ~freq_select_i;
    assign cal_store_b_o           = s_q.regs.dual | freq_select_i;

    // duration hint only meaningful for the legacy routine
    always_comb begin
        cal_time_est_o = 18'h00000;
        if (!s_q.regs.select) begin
            unique case (s_q.regs.wait_sel)
                2'h0: cal_time_est_o = SBVC_TIME_OLD_0;
                2'h1: cal_time_est_o = SBVC_TIME_OLD_1;
                2'h2: cal_time_est_o = SBVC_TIME_OLD_2;
                2'h3: cal_time_est_o = SBVC_TIME_OLD_3;
            endcase
        end
    end

    // other lock sources live elsewhere and read as 0 here
    always_comb begin
        lock_o = 1'b0;
        if (lock_select_i == SBVC_LOCK_CAL_DONE) begin
            lock_o = ~s_q.cal_done;
        end else if (lock_select_i == SBVC_LOCK_ONE) begin
            lock_o = 1'b1;
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_start_self_clear: assert property (cal_start_o |=> !s_q.regs.start && !cal_start_o)
        else $error("start bit did not clear after launch");
    a_start_needs_write: assert property ($rose(cal_start_o) |-> $past(s_q.bitcnt) == SBVC_BIT_LAST
        && $past(s_q.addr) == SBVC_OFS_CAL && $past(s_q.wr))
        else $error("calibration launched without a write");
    a_dual_both_sets: assert property (s_q.regs.dual |-> cal_store_a_o && cal_store_b_o)
        else $error("dual store not writing both sets");
    a_single_set_sel: assert property (!s_q.regs.dual |-> cal_store_a_o != cal_store_b_o
        && cal_store_b_o == freq_select_i)
        else $error("single store on wrong set");
    a_new_divider: assert property (s_q.regs.select && s_q.regs.wait_sel == 2'h2 |-> cal_divider_o == 9'h028)
        else $error("new routine divider wrong");
    a_old_divider: assert property (!s_q.regs.select && s_q.regs.wait_sel == 2'h1 |-> cal_divider_o == 9'h080)
        else $error("legacy routine divider wrong");
    a_old_duration: assert property (!s_q.regs.select && s_q.regs.wait_sel == 2'h3 |-> cal_time_est_o == 18'h30D40)
        else $error("legacy duration wrong");
    // carry into bit 3 only from the top code, so the range is 1 to 8
    a_dac_start: assert property (calibration_dac_start_o[2:0] == s_q.regs.iterate + 3'h1
        && calibration_dac_start_o[3] == (s_q.regs.iterate == 3'h7))
        else $error("dac start value wrong");
    a_lock_complete: assert property (cal_done_i && lock_select_i == SBVC_LOCK_CAL_DONE
        ##1 lock_select_i == SBVC_LOCK_CAL_DONE |-> !lock_o)
        else $error("lock pin not low after completion");
    a_reserved_zero: assert property (s_q.bitcnt == SBVC_BIT_RW && rise && s_q.addr == SBVC_OFS_SWING
        |=> s_q.rd[5:3] == 3'h0)
        else $error("reserved bits not read as zero");
    a_bw_write: assert property (rise && s_q.bitcnt == SBVC_BIT_LAST && s_q.wr && s_q.addr == SBVC_OFS_BW
        && !s_q.psel_n |=> loop_bandwidth_factor_o == $past(wdata))
        else $error("bandwidth factor not stored");
endmodule
`default_nettype wire

// ===== rtl/sbvc_pkg.sv
/*
 * package of the synthesiser buffer and vco calibration register bank:
 * offsets, field positions, reset values, timing figures, carrier types.
 * assumes nothing beyond a systemverilog compiler.
 */
package sbvc_pkg;
    // register offsets on the serial configuration bus
    localparam logic [6:0] SBVC_OFS_SWING   = 7'h18;
    localparam logic [6:0] SBVC_OFS_CURRENT = 7'h19;
    localparam logic [6:0] SBVC_OFS_BW      = 7'h1A;
    localparam logic [6:0] SBVC_OFS_CAL     = 7'h1B;

    // field positions
    localparam int SBVC_POS_PRE     = 6;
    localparam int SBVC_POS_START   = 7;
    localparam int SBVC_POS_DUAL    = 6;
    localparam int SBVC_POS_WAIT    = 4;
    localparam int SBVC_POS_SELECT  = 3;

    // reset values per field
    localparam logic [1:0] SBVC_RST_PRE_SWING   = 2'h3;
    localparam logic [2:0] SBVC_RST_TX_SWING    = 3'h1;
    localparam logic [1:0] SBVC_RST_PRE_CURRENT = 2'h1;
    localparam logic [2:0] SBVC_RST_TX_CURRENT  = 3'h5;
    localparam logic [7:0] SBVC_RST_BW          = 8'h86;
    localparam logic       SBVC_RST_START       = 1'h0;
    localparam logic       SBVC_RST_DUAL        = 1'h0;
    localparam logic [1:0] SBVC_RST_WAIT        = 2'h0;
    localparam logic       SBVC_RST_SELECT      = 1'h1;
    localparam logic [2:0] SBVC_RST_ITERATE     = 3'h5;

    // lock output selection codes for calibration complete and constant one
    localparam logic [3:0] SBVC_LOCK_CAL_DONE = 4'h5;
    localparam logic [3:0] SBVC_LOCK_ONE      = 4'h1;

    // serial frame layout
    localparam logic [4:0] SBVC_BIT_RW   = 5'h07;
    localparam logic [4:0] SBVC_BIT_LAST = 5'h0F;

    // calibration clock dividers, new routine then legacy routine
    localparam logic [8:0] SBVC_DIV_NEW_0 = 9'h008;
    localparam logic [8:0] SBVC_DIV_NEW_1 = 9'h010;
    localparam logic [8:0] SBVC_DIV_NEW_2 = 9'h028;
    localparam logic [8:0] SBVC_DIV_NEW_3 = 9'h050;
    localparam logic [8:0] SBVC_DIV_OLD_0 = 9'h050;
    localparam logic [8:0] SBVC_DIV_OLD_1 = 9'h080;
    localparam logic [8:0] SBVC_DIV_OLD_2 = 9'h0A0;
    localparam logic [8:0] SBVC_DIV_OLD_3 = 9'h100;

    // legacy calibration duration in reference periods
    localparam logic [17:0] SBVC_TIME_OLD_0 = 18'h15F90;
    localparam logic [17:0] SBVC_TIME_OLD_1 = 18'h1ADB0;
    localparam logic [17:0] SBVC_TIME_OLD_2 = 18'h1FBD0;
    localparam logic [17:0] SBVC_TIME_OLD_3 = 18'h30D40;

    typedef struct packed {
        logic [1:0] pre_swing;
        logic [2:0] tx_swing;
        logic [1:0] pre_current;
        logic [2:0] tx_current;
        logic [7:0] bw;
        logic       start;
        logic       dual;
        logic [1:0] wait_sel;
        logic       select;
        logic [2:0] iterate;
    } sbvc_regs_type;

    typedef struct packed {
        logic [2:0] pclk;
        logic [2:0] pdi;
        logic [2:0] psel_n;
    } sbvc_sync_type;

    typedef struct packed {
        sbvc_sync_type sync;
        logic          pclk;
        logic          pdi;
        logic          psel_n;
        logic [4:0]    bitcnt;
        logic [7:0]    shift;
        logic [6:0]    addr;
        logic          wr;
        logic [7:0]    rd;
        logic          pdo;
        sbvc_regs_type regs;
        logic          cal_pulse;
        logic          cal_done;
    } sbvc_state_type;

    function automatic logic [8:0] sbvc_divider(input logic sel, input logic [1:0] w);
        logic [8:0] d;
        d = 9'h000;
        unique case ({sel, w})
            3'h4: d = SBVC_DIV_NEW_0;
            3'h5: d = SBVC_DIV_NEW_1;
            3'h6: d = SBVC_DIV_NEW_2;
            3'h7: d = SBVC_DIV_NEW_3;
            3'h0: d = SBVC_DIV_OLD_0;
            3'h1: d = SBVC_DIV_OLD_1;
            3'h2: d = SBVC_DIV_OLD_2;
            3'h3: d = SBVC_DIV_OLD_3;
        endcase
        return d;
    endfunction

    function automatic logic [7:0] sbvc_read(input sbvc_regs_type r, input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            SBVC_OFS_SWING:   v = {r.pre_swing, 3'h0, r.tx_swing};
            SBVC_OFS_CURRENT: v = {r.pre_current, 3'h0, r.tx_current};
            SBVC_OFS_BW:      v = r.bw;
            SBVC_OFS_CAL:     v = {r.start, r.dual, r.wait_sel, r.select, r.iterate};
            default:          v = 8'h00;
        endcase
        return v;
    endfunction
endpackage

// ===== test/sbvc_host.sv
/*
 * host model for the serial configuration bus of the sbvc register bank.
 * assumes a 25 MHz mclk_i and a design that filters the bus pins.
 */
`timescale 1ns/1ps
`default_nettype none
module sbvc_host (
    input  wire logic mclk_i,
    input  wire logic pdo_i,
    output var logic  pclk_o,
    output var logic  pdi_o,
    output var logic  psel_n_o
);
    // twice the filter minimum per phase, trades speed for margin
    localparam int PH = 8;
    initial begin
        pclk_o   = 1'b0;
        pdi_o    = 1'b1;
        psel_n_o = 1'b1;
    end
    task automatic xfer(input logic [6:0] a, input logic wr, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {a, wr, d};
        q = 8'h00;
        @(posedge mclk_i);
        psel_n_o <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            pdi_o <= f[i];
            repeat (PH) @(posedge mclk_i);
            if (i < 8) begin
                q[i] = pdo_i;
            end
            pclk_o <= 1'b1;
            repeat (PH) @(posedge mclk_i);
            pclk_o <= 1'b0;
        end
        repeat (PH) @(posedge mclk_i);
        psel_n_o <= 1'b1;
        // released line shows the inverse so a stale bit is never taken
        pdi_o    <= ~f[0];
        repeat (PH) @(posedge mclk_i);
    endtask
endmodule
`default_nettype wire

// ===== test/test_synth_buffer_and_vco_calibration_regs.sv
/*
 * self-checking bench of the sbvc register bank against an integer model.
 * assumes sbvc_host drives the serial pins; calibration engine is the bench.
 */
`timescale 1ns/1ps
`default_nettype none
module test_synth_buffer_and_vco_calibration_regs
    import sbvc_pkg::*;
();
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        freq_select_i = 1'b0;
    logic [3:0]  lock_select_i = 4'h0;
    logic        cal_done_i = 1'b0;
    logic        pclk, pdi, psel_n, pdo, cal_start_o, cal_store_a_o, cal_store_b_o, lock_o;
    logic [1:0]  prescaler_swing_o, prescaler_current_o;
    logic [2:0]  tx_lo_swing_o, tx_lo_current_o;
    logic [7:0]  loop_bandwidth_factor_o;
    logic [8:0]  cal_divider_o;
    logic [17:0] cal_time_est_o;
    logic [3:0]  calibration_dac_start_o;
    logic        cmpl;
    logic [7:0]  mdl [4];
    int          error_cnt = 0;
    int          tests_run = 0;
    int          starts = 0;
    int          dnew [4] = '{8, 16, 40, 80};
    int          dold [4] = '{80, 128, 160, 256};
    int          told [4] = '{90000, 110000, 130000, 200000};

    sbvc_regs u_sbvc_regs (.mclk_i, .rst_i, .pclk_i(pclk), .pdi_i(pdi), .psel_n_i(psel_n), .pdo_o(pdo),
        .freq_select_i, .lock_select_i, .cal_done_i, .prescaler_swing_o, .tx_lo_swing_o,
        .prescaler_current_o, .tx_lo_current_o, .loop_bandwidth_factor_o, .cal_start_o, .cal_divider_o,
        .cal_time_est_o, .calibration_dac_start_o, .cal_store_a_o, .cal_store_b_o, .lock_o);
    sbvc_host u_host (.mclk_i, .pdo_i(pdo), .pclk_o(pclk), .pdi_o(pdi), .psel_n_o(psel_n));

    always #20 mclk_i = ~mclk_i;

    // done wins over a launch in the same cycle
    always @(posedge mclk_i) begin
        if (cal_start_o === 1'b1) begin
            starts++;
        end
        if (rst_i) begin
            cmpl <= 1'b0;
        end else if (cal_done_i) begin
            cmpl <= 1'b1;
        end else if (cal_start_o) begin
            cmpl <= 1'b0;
        end
    end

    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        u_host.xfer(a, 1'b1, d, r);
        if (a == SBVC_OFS_CAL) begin
            mdl[3] = d & 8'h7F;
        end else if (a == SBVC_OFS_BW) begin
            mdl[2] = d;
        end else if (a == SBVC_OFS_SWING || a == SBVC_OFS_CURRENT) begin
            mdl[a[0]] = d & 8'hC7;
        end
    endtask

    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        logic [7:0] r;
        u_host.xfer(a, 1'b0, 8'($urandom), r);
        chk(18'(r), 18'(e));
    endtask

    function automatic logic lexp();
        return lock_select_i == 4'h1 ? 1'b1 : (lock_select_i == 4'h5 ? ~cmpl : 1'b0);
    endfunction

    task automatic check_all();
        logic [8:0]  dv;
        logic [17:0] tm;
        dv = 9'(mdl[3][3] ? dnew[mdl[3][5:4]] : dold[mdl[3][5:4]]);
        tm = mdl[3][3] ? 18'h0 : 18'(told[mdl[3][5:4]]);
        chk(18'(prescaler_swing_o), 18'(mdl[0][7:6]));
        chk(18'(tx_lo_swing_o), 18'(mdl[0][2:0]));
        chk(18'(prescaler_current_o), 18'(mdl[1][7:6]));
        chk(18'(tx_lo_current_o), 18'(mdl[1][2:0]));
        chk(18'(loop_bandwidth_factor_o), 18'(mdl[2]));
        chk(18'(cal_divider_o), 18'(dv));
        chk(cal_time_est_o, tm);
        chk(18'(calibration_dac_start_o), 18'(mdl[3][2:0]) + 18'h1);
        chk(18'(cal_store_a_o), 18'(mdl[3][6] | !freq_select_i));
        chk(18'(cal_store_b_o), 18'(mdl[3][6] | freq_select_i));
        chk(18'(lock_o), 18'(lexp()));
        for (int i = 0; i < 4; i++) begin
            rd_chk(SBVC_OFS_SWING + 7'(i), mdl[i]);
        end
    endtask

    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        rst_i <= 1'b0;
        mdl = '{8'hC1, 8'h45, 8'h86, 8'h0D};
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // about 120 frames of 273 cycles each; twice that before giving up
    initial begin
        repeat (60000) @(posedge mclk_i);
        error_cnt++;
        tally_and_finish();
    end

    initial begin
        int s;
        void'($urandom(14157));
        do_reset();
        check_all();
        $display("test reset done");
        for (int n = 0; n < 8; n++) begin
            @(posedge mclk_i);
            freq_select_i <= 1'($urandom);
            wr(7'h18 + 7'($urandom % 4), 8'($urandom));
            check_all();
        end
        wr(7'h1C, 8'hFF);
        wr(7'h00, 8'h5A);
        rd_chk(7'h1C, 8'h00);
        check_all();
        $display("test random and unmapped done");
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk_i);
            freq_select_i <= i[1];
            wr(SBVC_OFS_CAL, {1'b0, i[0], i[1:0], i[2], i[2:0]});
            check_all();
        end
        $display("test calibration fields done");
        s = starts;
        wr(SBVC_OFS_CAL, 8'hBC);
        chk(18'(starts - s), 18'h1);
        wr(SBVC_OFS_CAL, 8'h8C);
        wr(SBVC_OFS_CAL, 8'h0C);
        chk(18'(starts - s), 18'h2);
        check_all();
        $display("test launch done");
        for (int c = 0; c < 16; c++) begin
            lock_select_i <= 4'(c);
            repeat (2) @(posedge mclk_i);
            chk(18'(lock_o), 18'(lexp()));
        end
        lock_select_i <= 4'h5;
        @(posedge mclk_i);
        cal_done_i <= 1'b1;
        @(posedge mclk_i);
        cal_done_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk(18'(lock_o), 18'h0);
        wr(SBVC_OFS_CAL, 8'h80);
        chk(18'(lock_o), 18'h1);
        $display("test lock output done");
        for (int b = 0; b < 2; b++) begin
            wr(SBVC_OFS_SWING, b == 1 ? 8'h00 : 8'h04);
            wr(SBVC_OFS_CURRENT, b == 1 ? 8'h04 : 8'h02);
            wr(SBVC_OFS_BW, 8'(int'(146.0 + 16.0 * $ln(14.7456 / 7.126) / $ln(2.0))));
            check_all();
        end
        do_reset();
        check_all();
        $display("test recommended and second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
